// [core/ppb_pkg.sv]
////////////////////////////////////////////////////////////////////////////
// constants, types and helpers for both bus ends
package ppb_pkg;

  // bus widths
  localparam int AD_W  = 32;             // address/data lines
  localparam int CBE_W = 4;              // command/byte-enable lines
  localparam int LEN_W = 4;              // burst length counter width

  // command codes
  localparam logic [CBE_W-1:0] CMD_DAC   = 4'hD;  // dual address cycle
  localparam logic [CBE_W-1:0] CMD_MRD   = 4'h6;  // memory read
  localparam logic [CBE_W-1:0] CMD_MWR   = 4'h7;  // memory write

  // values driven while the bus is parked
  localparam logic [AD_W-1:0]  PARK_AD   = 32'h0000_0000;
  localparam logic [CBE_W-1:0] PARK_CBE  = 4'h0;

  // reset values of the pin drivers
  localparam logic [AD_W-1:0]  RST_AD    = 32'h0000_0000;
  localparam logic [CBE_W-1:0] RST_CBE   = 4'hF;
  localparam logic             RST_CTL   = 1'b1;  // control lines high
  localparam logic [LEN_W-1:0] RST_LEN   = 4'h0;

  // initiator (bridge) sequencer states
  typedef enum logic [2:0] {
    BR_IDLE, BR_ADDR, BR_ADDR2, BR_DATA, BR_REL
  } ppb_br_state_t;

  // target (agent) sequencer states
  typedef enum logic [2:0] {
    AG_IDLE, AG_ADDR2, AG_TURN, AG_DATA, AG_REL
  } ppb_ag_state_t;

  // even parity bit over the 36 bits of address/data and command/enables
  function automatic logic ppb_par36(input logic [AD_W-1:0]  ad,
                                     input logic [CBE_W-1:0] cbe);
    return ^{ad, cbe};
  endfunction

  // odd command codes are writes, even codes are reads
  function automatic logic ppb_is_write(input logic [CBE_W-1:0] cmd);
    return cmd[0];
  endfunction

endpackage

// [core/ppb_bus_if.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// primary bus wires: one level per line from its drivers
interface ppb_bus_if;
  import ppb_pkg::*;

  // bridge (initiator) drivers
  logic [AD_W-1:0]  b_ad;       // address / write data
  logic             b_ad_oe;    // bridge drives ad
  logic [CBE_W-1:0] b_cbe_n;    // command / byte enables
  logic             b_cbe_oe;   // bridge drives cbe
  logic             b_par;      // parity out
  logic             b_par_oe;   // bridge drives parity
  logic             b_frame_n;  // frame out
  logic             b_frame_oe; // bridge drives frame
  logic             b_irdy_n;   // initiator ready out
  logic             b_irdy_oe;  // bridge drives irdy

  // agent (target) drivers
  logic [AD_W-1:0]  a_ad;       // read data
  logic             a_ad_oe;    // agent drives ad
  logic             a_par;      // parity out
  logic             a_par_oe;   // agent drives parity
  logic             a_trdy_n;   // target ready out
  logic             a_trdy_oe;  // agent drives trdy

  // resolved line levels
  logic [AD_W-1:0]  ad;
  logic [CBE_W-1:0] cbe_n;
  logic             par;
  logic             frame_n;
  logic             irdy_n;
  logic             trdy_n;

  // undriven data lines show inverted levels, controls pull high
  assign ad      = b_ad_oe ? b_ad : (a_ad_oe ? a_ad : ~b_ad);
  assign cbe_n   = b_cbe_oe ? b_cbe_n : ~b_cbe_n;
  assign par     = b_par_oe ? b_par : (a_par_oe ? a_par : ~b_par);
  assign frame_n = b_frame_oe ? b_frame_n : 1'b1;
  assign irdy_n  = b_irdy_oe ? b_irdy_n : 1'b1;
  assign trdy_n  = a_trdy_oe ? a_trdy_n : 1'b1;

  // initiator end
  modport bridge (
    output b_ad, b_ad_oe, b_cbe_n, b_cbe_oe, b_par, b_par_oe,
    output b_frame_n, b_frame_oe, b_irdy_n, b_irdy_oe,
    input  ad, cbe_n, par, frame_n, irdy_n, trdy_n
  );

  // target end
  modport agent (
    output a_ad, a_ad_oe, a_par, a_par_oe, a_trdy_n, a_trdy_oe,
    input  ad, cbe_n, par, frame_n, irdy_n, trdy_n
  );

endinterface

// [core/ppb_agent_end.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// target end of the primary bus: accepts writes, returns read data
module ppb_agent_end
  import ppb_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // bus side
  ppb_bus_if.agent              bus,
  // user: readiness and read data
  input  wire logic             tgt_ready,
  input  wire logic [AD_W-1:0]  rd_data,
  output logic                  rd_take,
  // user: decoded address phase
  output logic                  addr_valid,
  output logic [CBE_W-1:0]      cmd,
  output logic [AD_W-1:0]       addr_lo,
  output logic [AD_W-1:0]       addr_hi,
  // user: received write data
  output logic                  wr_valid,
  output logic [AD_W-1:0]       wr_data,
  output logic [CBE_W-1:0]      wr_be_n,
  output logic                  par_err
);

  ppb_ag_state_t    state_r;     // sequencer state
  logic [CBE_W-1:0] cmd_r;       // captured command
  logic [AD_W-1:0]  ad_r;        // read data driver
  logic             ad_oe_r;     // read data enable
  logic             par_r;       // parity driver
  logic             par_oe_r;    // parity enable
  logic             trdy_r;      // trdy driver
  logic             trdy_oe_r;   // trdy enable
  logic             take_r;      // read word consumed
  logic             chk_r;       // write data to check next edge
  logic             cap_par_r;   // parity computed on received word
  logic             perr_r;      // parity mismatch pulse
  logic             av_r;        // address decoded pulse
  logic [AD_W-1:0]  alo_r;       // low address
  logic [AD_W-1:0]  ahi_r;       // high address
  logic             wv_r;        // write word pulse
  logic [AD_W-1:0]  wd_r;        // write word
  logic [CBE_W-1:0] wbe_r;       // write byte enables

  logic addr_ph;   // frame just asserted on an idle bus
  logic xfer;      // data phase completes at this edge
  logic wr;        // current transaction is a write
  logic load;      // put next read word on the bus

  // edge conditions
  assign addr_ph = (state_r == AG_IDLE) && !bus.frame_n && bus.irdy_n;
  assign wr      = ppb_is_write(cmd_r);
  // both ready lines low at one edge ends the data phase [RQ17]
  assign xfer    = (state_r == AG_DATA) && trdy_oe_r && !trdy_r &&
                   !bus.irdy_n;
  // read word loaded as trdy asserts [RQ15]
  assign load    = !wr && tgt_ready &&
                   (((state_r == AG_TURN)) ||
                    ((state_r == AG_DATA) && trdy_r) ||
                    (xfer && !bus.frame_n));

  ////////////////////////////////////////////////////////////////////////
  // sequencer and address capture
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= AG_IDLE;
      cmd_r   <= RST_CBE;
      alo_r   <= RST_AD;
      ahi_r   <= RST_AD;
      av_r    <= 1'b0;
    end else begin
      av_r <= 1'b0;
      unique case (state_r)
        AG_IDLE: if (addr_ph) begin
          // first address phase carries command or dual marker [RQ3]
          cmd_r   <= bus.cbe_n;
          alo_r   <= bus.ad;                          // [RQ1]
          ahi_r   <= RST_AD;
          state_r <= (bus.cbe_n == CMD_DAC) ? AG_ADDR2 : AG_TURN;
          av_r    <= (bus.cbe_n != CMD_DAC);
        end
        AG_ADDR2: begin
          // second phase: real command and upper address [RQ3]
          cmd_r   <= bus.cbe_n;
          ahi_r   <= bus.ad;
          av_r    <= 1'b1;
          state_r <= AG_TURN;
        end
        AG_TURN: state_r <= AG_DATA;
        AG_DATA: if (xfer && bus.frame_n) begin
          // frame high at completion marks the final phase [RQ11]
          state_r <= AG_REL;
        end
        AG_REL:  state_r <= AG_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // target ready line
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trdy_r    <= RST_CTL;
      trdy_oe_r <= 1'b0;
    end else if (addr_ph) begin
      trdy_r    <= 1'b1;                 // driven high from the clock after the first address phase
      trdy_oe_r <= 1'b1;
    end else if (state_r == AG_REL) begin
      trdy_oe_r <= 1'b0;                 // float after one high clock [RQ12]
    end else if (xfer && bus.frame_n) begin
      trdy_r    <= 1'b1;                 // drive deasserted one clock [RQ12]
    end else if (state_r == AG_TURN ||
                 (state_r == AG_DATA && (trdy_r || xfer))) begin
      // assert only when able; once low, held until completion [RQ16]
      trdy_r    <= !tgt_ready;           // [RQ15]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data driver
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ad_r    <= RST_AD;
      ad_oe_r <= 1'b0;
      take_r  <= 1'b0;
    end else begin
      take_r <= load;
      if (load) begin
        ad_r    <= rd_data;              // target drives read data [RQ1]
        ad_oe_r <= 1'b1;
      end else if (xfer && bus.frame_n) begin
        ad_oe_r <= 1'b0;                 // released after last phase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parity follows our data by one clock, over the bus enables [RQ6]
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      par_r    <= 1'b0;
      par_oe_r <= 1'b0;
    end else begin
      par_r    <= ppb_par36(ad_r, bus.cbe_n);        // [RQ7]
      par_oe_r <= ad_oe_r;                           // [RQ8]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write data capture and parity check on received words
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wv_r      <= 1'b0;
      wd_r      <= RST_AD;
      wbe_r     <= RST_CBE;
      chk_r     <= 1'b0;
      cap_par_r <= 1'b0;
      perr_r    <= 1'b0;
    end else begin
      wv_r      <= xfer && wr;
      chk_r     <= xfer && wr;
      cap_par_r <= ppb_par36(bus.ad, bus.cbe_n);
      if (xfer && wr) begin
        wd_r  <= bus.ad;
        wbe_r <= bus.cbe_n;                          // [RQ4]
      end
      // compare parity one clock after the data [RQ10]
      perr_r <= chk_r && (bus.par != cap_par_r);
    end
  end

  // pin and user outputs, all from flip-flops
  assign bus.a_ad      = ad_r;
  assign bus.a_ad_oe   = ad_oe_r;
  assign bus.a_par     = par_r;
  assign bus.a_par_oe  = par_oe_r;
  assign bus.a_trdy_n  = trdy_r;
  assign bus.a_trdy_oe = trdy_oe_r;
  assign rd_take       = take_r;
  assign addr_valid    = av_r;
  assign cmd           = cmd_r;
  assign addr_lo       = alo_r;
  assign addr_hi       = ahi_r;
  assign wr_valid      = wv_r;
  assign wr_data       = wd_r;
  assign wr_be_n       = wbe_r;
  assign par_err       = perr_r;

endmodule

// [core/ppb_bridge_end.sv]
`timescale 1ns/10ps
// Function
// [RQ1] address then data share one bus
// [RQ2] park address/data when idle with grant
// [RQ3] command in address phases, dual first
// [RQ4] byte enables in every data phase
// [RQ5] park command lines when idle with grant
// [RQ6] even parity over 36 bits
// [RQ7] parity one clock after data driver
// [RQ8] parity floats one clock after data
// [RQ9] parked parity one clock after parking
// [RQ10] receiver checks parity against own
// [RQ11] frame held until final data phase
// [RQ12] release control: one high clock, float
// [RQ13] irdy only with data or room
// [RQ14] irdy held until phase completes
// [RQ15] trdy only when data accepted/driven
// [RQ16] trdy held until phase completes
// [RQ17] both ready at edge completes phase
////////////////////////////////////////////////////////////////////////////
// initiator end of the primary bus: bursts, parking, parity
module ppb_bridge_end
  import ppb_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // bus side
  ppb_bus_if.bridge             bus,
  // arbitration grant, active low
  input  wire logic             gnt_n,
  // user: transaction request
  input  wire logic             req,
  input  wire logic [CBE_W-1:0] cmd,
  input  wire logic             dual,
  input  wire logic [AD_W-1:0]  addr_lo,
  input  wire logic [AD_W-1:0]  addr_hi,
  input  wire logic [CBE_W-1:0] be_n,
  input  wire logic [LEN_W-1:0] len,
  output logic                  ack,
  output logic                  busy,
  // user: write data stream
  input  wire logic [AD_W-1:0]  wr_data,
  output logic                  wr_take,
  // user: read data stream and error
  output logic                  rd_valid,
  output logic [AD_W-1:0]       rd_data,
  output logic                  par_err
);

  ppb_br_state_t    state_r;     // sequencer state
  ppb_br_state_t    state_nxt;   // next sequencer state
  logic [CBE_W-1:0] cmd_r;       // latched command
  logic [CBE_W-1:0] be_r;        // latched byte enables
  logic [AD_W-1:0]  ahi_r;       // latched upper address
  logic [LEN_W-1:0] left_r;      // data phases still to go
  logic             dual_r;      // two address phases
  logic             wr_r;        // transaction is a write

  logic [AD_W-1:0]  ad_r;        // ad driver
  logic             ad_oe_r;     // ad enable
  logic [CBE_W-1:0] cbe_r;       // cbe driver
  logic             cbe_oe_r;    // cbe enable
  logic             par_r;       // parity driver
  logic             par_oe_r;    // parity enable
  logic             frame_r;     // frame driver
  logic             frame_oe_r;  // frame enable
  logic             irdy_r;      // irdy driver
  logic             irdy_oe_r;   // irdy enable

  logic             ack_r;       // request taken pulse
  logic             busy_r;      // transaction in progress
  logic             take_r;      // write word consumed pulse
  logic             rv_r;        // read word pulse
  logic [AD_W-1:0]  rd_r;        // read word
  logic             chk_r;       // read word to check next edge
  logic             cap_par_r;   // parity computed on read word
  logic             perr_r;      // parity mismatch pulse

  logic bus_idle;  // no frame and no irdy on the bus
  logic go;        // request accepted at this edge
  logic park;      // idle with grant: hold the lines
  logic xfer;      // data phase completes at this edge
  logic last;      // completing phase is the final one
  logic load;      // put next write word on the bus

  ////////////////////////////////////////////////////////////////////////
  // edge conditions
  assign bus_idle = bus.frame_n && bus.irdy_n;
  assign go       = (state_r == BR_IDLE) && req && !gnt_n && bus_idle;
  assign park     = (state_r == BR_IDLE) && !gnt_n && bus_idle;
  // both ready lines low at the edge ends the phase [RQ17]
  assign xfer     = (state_r == BR_DATA) && irdy_oe_r && !irdy_r &&
                    !bus.trdy_n;
  assign last     = (left_r == 4'h1);
  // next write word after the address or a completed phase
  assign load     = wr_r &&
                    (((state_r == BR_ADDR) && !dual_r) ||
                     (state_r == BR_ADDR2) ||
                     (xfer && !last));

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      BR_IDLE:  if (go) state_nxt = BR_ADDR;
      BR_ADDR:  state_nxt = dual_r ? BR_ADDR2 : BR_DATA;
      BR_ADDR2: state_nxt = BR_DATA;
      BR_DATA:  if (xfer && last) state_nxt = BR_REL;
      BR_REL:   state_nxt = BR_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state, request latch and phase counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= BR_IDLE;
      cmd_r   <= RST_CBE;
      be_r    <= RST_CBE;
      ahi_r   <= RST_AD;
      left_r  <= RST_LEN;
      dual_r  <= 1'b0;
      wr_r    <= 1'b0;
      ack_r   <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ack_r   <= go;
      busy_r  <= (state_nxt != BR_IDLE);
      if (go) begin
        cmd_r  <= cmd;
        be_r   <= be_n;
        ahi_r  <= addr_hi;
        dual_r <= dual;
        wr_r   <= ppb_is_write(cmd);
        // zero length is taken as one phase
        left_r <= (len == RST_LEN) ? 4'h1 : len;
      end else if (xfer) begin
        left_r <= left_r - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame: low from start until the final phase begins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      frame_r    <= RST_CTL;
      frame_oe_r <= 1'b0;
    end else if (go) begin
      frame_r    <= 1'b0;                            // [RQ11]
      frame_oe_r <= 1'b1;
    end else if (state_nxt == BR_DATA && state_r != BR_DATA) begin
      frame_r    <= last;                // single phase: high at once
    end else if (xfer && left_r == 4'h2) begin
      frame_r    <= 1'b1;                // next phase is the final one
    end else if (xfer && last) begin
      frame_oe_r <= 1'b0;                // high already, now float [RQ12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // initiator ready
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irdy_r    <= RST_CTL;
      irdy_oe_r <= 1'b0;
    end else if (go) begin
      irdy_r    <= 1'b1;                 // driven high in address phase
      irdy_oe_r <= 1'b1;
    end else if (state_nxt == BR_DATA && state_r != BR_DATA) begin
      // write data is loaded, reads always accepted [RQ13]
      irdy_r    <= 1'b0;
    end else if (xfer && last) begin
      irdy_r    <= 1'b1;                 // one clock high [RQ12]
    end else if (state_r == BR_REL) begin
      irdy_oe_r <= 1'b0;                 // then float [RQ12]
    end
    // between phases irdy stays low until completion [RQ14]
  end

  ////////////////////////////////////////////////////////////////////////
  // address/data and command/enable drivers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ad_r     <= RST_AD;
      ad_oe_r  <= 1'b0;
      cbe_r    <= RST_CBE;
      cbe_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        BR_IDLE: begin
          if (go) begin
            ad_r  <= addr_lo;            // address first [RQ1]
            cbe_r <= dual ? CMD_DAC : cmd;               // [RQ3]
          end else begin
            ad_r  <= PARK_AD;            // parked level [RQ2]
            cbe_r <= PARK_CBE;           // parked level [RQ5]
          end
          ad_oe_r  <= go || park;        // [RQ2]
          cbe_oe_r <= go || park;        // [RQ5]
        end
        BR_ADDR: begin
          if (dual_r) begin
            ad_r  <= ahi_r;
            cbe_r <= cmd_r;              // real command second [RQ3]
          end else begin
            cbe_r <= be_r;               // [RQ4]
            if (wr_r) ad_r <= wr_data;   // write data [RQ1]
            ad_oe_r <= wr_r;             // read: turnaround
          end
        end
        BR_ADDR2: begin
          cbe_r <= be_r;                 // [RQ4]
          if (wr_r) ad_r <= wr_data;
          ad_oe_r <= wr_r;
        end
        BR_DATA: begin
          if (load) ad_r <= wr_data;
          if (xfer && last) begin
            ad_oe_r  <= 1'b0;
            cbe_oe_r <= 1'b0;
          end
        end
        BR_REL: begin
          ad_oe_r  <= 1'b0;
          cbe_oe_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parity trails ad by one clock, also while parked
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      par_r    <= 1'b0;
      par_oe_r <= 1'b0;
    end else begin
      par_r    <= ppb_par36(ad_r, cbe_r);            // [RQ6] [RQ7] [RQ9]
      par_oe_r <= ad_oe_r;                           // [RQ8] [RQ9]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // user streams and read parity check
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      take_r    <= 1'b0;
      rv_r      <= 1'b0;
      rd_r      <= RST_AD;
      chk_r     <= 1'b0;
      cap_par_r <= 1'b0;
      perr_r    <= 1'b0;
    end else begin
      take_r    <= load;
      rv_r      <= xfer && !wr_r;
      chk_r     <= xfer && !wr_r;
      cap_par_r <= ppb_par36(bus.ad, cbe_r);
      if (xfer && !wr_r) rd_r <= bus.ad;
      // target parity arrives one clock after its data [RQ10]
      perr_r    <= chk_r && (bus.par != cap_par_r);
    end
  end

  // pin and user outputs, all from flip-flops
  assign bus.b_ad       = ad_r;
  assign bus.b_ad_oe    = ad_oe_r;
  assign bus.b_cbe_n    = cbe_r;
  assign bus.b_cbe_oe   = cbe_oe_r;
  assign bus.b_par      = par_r;
  assign bus.b_par_oe   = par_oe_r;
  assign bus.b_frame_n  = frame_r;
  assign bus.b_frame_oe = frame_oe_r;
  assign bus.b_irdy_n   = irdy_r;
  assign bus.b_irdy_oe  = irdy_oe_r;
  assign ack            = ack_r;
  assign busy           = busy_r;
  assign wr_take        = take_r;
  assign rd_valid       = rv_r;
  assign rd_data        = rd_r;
  assign par_err        = perr_r;

endmodule

// [verification/ppb_bus_properties.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// protocol checks on the shared wires
module ppb_bus_properties
  import ppb_pkg::*;
(
  // clock, reset and grant
  input logic             core_clk,
  input logic             rst_n,
  input logic             gnt_n,
  // driver enables and driven levels
  input logic             b_ad_oe,
  input logic             a_ad_oe,
  input logic             b_cbe_oe,
  input logic             b_par_oe,
  input logic             a_par_oe,
  input logic             b_frame_n,
  input logic             b_frame_oe,
  input logic             b_irdy_oe,
  input logic             a_trdy_oe,
  // resolved line levels
  input logic [AD_W-1:0]  ad,
  input logic [CBE_W-1:0] cbe_n,
  input logic             par,
  input logic             frame_n,
  input logic             irdy_n,
  input logic             trdy_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // steps: final phase, irdy release, idle with grant
  sequence s_last; !irdy_n && !trdy_n && frame_n; endsequence
  sequence s_drop; irdy_n && b_irdy_oe ##1 !b_irdy_oe; endsequence
  sequence s_idle; !gnt_n && frame_n && irdy_n && trdy_n; endsequence
  property p_one_ad; !(b_ad_oe && a_ad_oe); endproperty
  a_one_ad: assert property (p_one_ad) else $error("ad fight");
  property p_park;
    s_idle [*5] |-> b_ad_oe && b_cbe_oe && ad == PARK_AD && cbe_n == PARK_CBE;
  endproperty
  a_park: assert property (p_park) else $error("not parked");
  property p_even;
    (b_par_oe || a_par_oe) && $past(b_ad_oe || a_ad_oe)
      |-> par == ^{$past(ad), $past(cbe_n)};
  endproperty
  a_even: assert property (p_even) else $error("bad parity");
  property p_par_on; $rose(b_ad_oe) |=> b_par_oe; endproperty
  a_par_on: assert property (p_par_on) else $error("par late");
  property p_b_par_off; $fell(b_ad_oe) |-> b_par_oe ##1 !b_par_oe; endproperty
  a_b_par_off: assert property (p_b_par_off) else $error("b par");
  property p_a_par_off; $fell(a_ad_oe) |-> a_par_oe ##1 !a_par_oe; endproperty
  a_a_par_off: assert property (p_a_par_off) else $error("a par");
  property p_frame_rel; $fell(b_frame_oe) |-> $past(b_frame_n); endproperty
  a_frame_rel: assert property (p_frame_rel) else $error("frame");
  property p_last; s_last |=> s_drop; endproperty
  a_last: assert property (p_last) else $error("irdy release");
  property p_irdy_hold; !irdy_n && trdy_n |=> !irdy_n; endproperty
  a_irdy_hold: assert property (p_irdy_hold) else $error("irdy");
  property p_trdy_hold; !trdy_n && irdy_n |=> !trdy_n; endproperty
  a_trdy_hold: assert property (p_trdy_hold) else $error("trdy");
  property p_trdy_rel;
    $rose(trdy_n) && a_trdy_oe && $past(frame_n) |=> !a_trdy_oe;
  endproperty
  a_trdy_rel: assert property (p_trdy_rel) else $error("trdy rel");
endmodule

// [verification/pci_primary_bus_signaling_bench.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// both ends joined, bursts checked word by word
module pci_primary_bus_signaling_bench;
  import ppb_pkg::*;
  // stimulus and observed signals
  logic             core_clk, rst_n, gnt_n, req, dual, tgt_ready;
  logic             ack, busy, wr_take, rd_valid, b_perr;
  logic             rd_take, addr_valid, wr_valid, a_perr;
  logic [CBE_W-1:0] cmd, be_n, a_cmd, a_be_n;
  logic [LEN_W-1:0] len;
  logic [AD_W-1:0]  addr_lo, addr_hi, b_rd, a_lo, a_hi, a_wr;
  logic [AD_W-1:0]  wq [16];  // words of the current burst
  int               wi, ri, wk, rk, cyc, miscompares, cmp_count;
  integer           seed = 32'h25A4A28B;
  ////////////////////////////////////////////////////////////////////////////
  ppb_bus_if u_bus ();
  ppb_bridge_end u_ppb_bridge_end (.core_clk(core_clk), .rst_n(rst_n),
    .bus(u_bus), .gnt_n(gnt_n), .req(req), .cmd(cmd), .dual(dual),
    .addr_lo(addr_lo), .addr_hi(addr_hi), .be_n(be_n), .len(len),
    .ack(ack), .busy(busy),
    .wr_data(wq[wi[3:0] + 4'(wr_take)]), .wr_take(wr_take),
    .rd_valid(rd_valid), .rd_data(b_rd), .par_err(b_perr));
  ppb_agent_end u_ppb_agent_end (.core_clk(core_clk), .rst_n(rst_n),
    .bus(u_bus), .tgt_ready(tgt_ready), .rd_data(wq[ri[3:0] + 4'(rd_take)]),
    .rd_take(rd_take), .addr_valid(addr_valid), .cmd(a_cmd),
    .addr_lo(a_lo), .addr_hi(a_hi), .wr_valid(wr_valid),
    .wr_data(a_wr), .wr_be_n(a_be_n), .par_err(a_perr));
  ppb_bus_properties u_ppb_bus_properties (.core_clk(core_clk),
    .rst_n(rst_n), .gnt_n(gnt_n), .b_ad_oe(u_bus.b_ad_oe),
    .a_ad_oe(u_bus.a_ad_oe), .b_cbe_oe(u_bus.b_cbe_oe),
    .b_par_oe(u_bus.b_par_oe), .a_par_oe(u_bus.a_par_oe),
    .b_frame_n(u_bus.b_frame_n), .b_frame_oe(u_bus.b_frame_oe),
    .b_irdy_oe(u_bus.b_irdy_oe), .a_trdy_oe(u_bus.a_trdy_oe),
    .ad(u_bus.ad), .cbe_n(u_bus.cbe_n), .par(u_bus.par),
    .frame_n(u_bus.frame_n), .irdy_n(u_bus.irdy_n), .trdy_n(u_bus.trdy_n));
  ////////////////////////////////////////////////////////////////////////////
  // expected burst length
  function automatic int f_len(input logic [LEN_W-1:0] l);
    return (l == 4'h0) ? 1 : int'(l);
  endfunction
  // compare, count, report
  task automatic chk(input string nm, input logic [AD_W-1:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock, random grant and target stalls
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    #1;
    tgt_ready <= ($random(seed) & 3) != 0;
    gnt_n <= ($random(seed) & 7) == 0;
  end
  // word pointers, user-side checks, timeout
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (wr_take === 1'b1) wi <= wi + 1;
    if (rd_take === 1'b1) ri <= ri + 1;
    if (addr_valid === 1'b1) begin
      chk("cmd", AD_W'(cmd), AD_W'(a_cmd));
      chk("addr lo", addr_lo, a_lo);
      chk("addr hi", dual ? addr_hi : '0, a_hi);
    end
    if (wr_valid === 1'b1) begin
      chk("wr data", wq[wk[3:0]], a_wr);
      chk("be", AD_W'(be_n), AD_W'(a_be_n));
      wk <= wk + 1;
    end
    if (rd_valid === 1'b1) begin
      chk("rd data", wq[rk[3:0]], b_rd);
      rk <= rk + 1;
    end
    if (rst_n) chk("par err", '0, AD_W'({b_perr, a_perr}));
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // one burst: corner lengths, then random
  task automatic xfer(input int k);
    @(posedge core_clk);
    #1;
    for (int i = 0; i < 16; i++)
      wq[i] = $random(seed);
    cmd = k[0] ? CMD_MWR : CMD_MRD;
    dual = k[1];
    len = (k < 2) ? 4'h0 : (k < 4) ? 4'hF : LEN_W'($random(seed));
    be_n = CBE_W'($random(seed));
    addr_lo = $random(seed);
    addr_hi = $random(seed);
    {wi, ri, wk, rk} = '0;
    req = 1'b1;
    do begin
      @(posedge core_clk);
      #1;
    end while (ack !== 1'b1);
    req = 1'b0;
    while (busy !== 1'b0) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    chk("words", AD_W'(f_len(len)), AD_W'(k[0] ? wk : rk));
  endtask
  initial begin
    {core_clk, rst_n, gnt_n, req, dual, tgt_ready} = 6'h0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (int k = 0; k < 24; k++)
      xfer(k);
    report_and_stop();
  end
endmodule
